// file: hdl/receive_slave_dma.sv
// Receive-only slave DMA engine with its staging FIFO
//
// Notes on behaviour
// - Slave DMA carries received frames only, never transmit traffic.
// - Channel select register picks request/grant pair 0, 1 or 2.
// - Start offset register holds offset of most recently moved frame.
// - Frame count low 12 bits count frames moved since last read; top reserved.
// - Byte count counts bytes moved since the previous read.
// - All-frames-by-DMA enable sends every received frame through DMA.
// - All-frames enable wins over auto-switch enable when both are set.
// - Host ring buffer is 16 Kbytes, or 64 Kbytes with size select set.
// - Buffer size only affects the start offset logic.
// - Request rises only once the whole frame is received and accepted; the code raises it as soon as a frame is pending in DMA mode.
// - Status word goes first, then length word, then frame data.
// - Without duty cycle, request stays high until the last word cycle starts, except while the FIFO has no data word ready.
// - With duty cycle, request high about 28 ms, low about 1.3 ms.
// - On completion update offset and counts, set flag, free on-chip space.
// - Completion raises an interrupt when its enable is set.
// - Each frame lost for lack of space bumps the lost frame counter.
// - Receive event reads as zero while DMA mode is active.
// - Frame count read commits covered space; next read frees it.
// - Frames written as words, each starting on a 32-bit boundary.
// - Delivered flag follows nonzero frame count, so a frame count read clears it.
`timescale 1ns/1ns
`default_nettype none

// ******************************************************************
// Staging FIFO between on-chip RAM reader and host transfer
// ******************************************************************
module rx_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];

  // Occupancy; ready is registered so it never depends on the source
  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count      <= '0;
      o_in_ready <= 1'b1;
    end
    else
    begin
      count      <= next_count;
      o_in_ready <= (next_count != CW'(DEPTH));
    end
  end

  // Pointers wrap at the depth, so any depth works
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // Storage carries no reset
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end
endmodule

// ******************************************************************
// Receive slave DMA engine
// ******************************************************************
module receive_slave_dma #(
  parameter int REQ_ON_CYCLES  = rx_dma_pkg::REQ_ON_CYC,
  parameter int REQ_OFF_CYCLES = rx_dma_pkg::REQ_OFF_CYC,
  parameter int LOST_W         = 10
) (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Register port
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [15:0]                 i_reg_addr,
  input  wire logic [15:0]                 i_reg_wdata,
  output logic [15:0]                      o_reg_rdata,
  // Configuration bits
  input  wire logic                        i_all_frames_by_dma_enable,
  input  wire logic                        i_auto_switch_dma_enable,
  input  wire logic                        i_host_buffer_size_select,
  input  wire logic                        i_request_duty_cycle_enable,
  input  wire logic                        i_frames_delivered_irq_enable,
  // On-chip receive side
  input  wire logic                        i_frame_pending,
  input  wire rx_dma_pkg::frame_hdr_t      i_frame_hdr,
  input  wire logic                        i_rx_valid,
  input  wire logic [15:0]                 i_rx_data,
  output logic                             o_rx_ready,
  output logic                             o_frame_free,
  input  wire logic                        i_frame_missed,
  input  wire logic [15:0]                 i_receive_event_word,
  output logic [15:0]                      o_receive_event_word,
  // Host DMA pins
  output logic [rx_dma_pkg::NUM_CHAN-1:0]  o_transfer_request_pin,
  input  wire logic [rx_dma_pkg::NUM_CHAN-1:0] i_transfer_grant_pin_n,
  output logic [15:0]                      o_data_out,
  output logic                             o_data_oe,
  // Status
  output logic                             o_frames_delivered_flag,
  output logic                             o_frames_delivered_irq,
  output logic [LOST_W-1:0]                o_lost_frame_counter
);
  localparam int NC = rx_dma_pkg::NUM_CHAN;

  rx_dma_pkg::dma_state_t state;
  rx_dma_pkg::frame_hdr_t hdr;
  logic [1:0]             chan;
  logic [15:0]            sof;
  logic [15:0]            wr_ofs;
  logic [rx_dma_pkg::FRAMES_W-1:0] frames;
  logic [15:0]            bytes;
  logic [17:0]            pending;
  logic [17:0]            committed;
  logic [17:0]            buf_size;
  logic [17:0]            frame_bytes;
  logic [16:0]            data_words;
  logic [17:0]            total_words;
  logic [17:0]            idx;
  logic [NC-1:0]          ack_s1;
  logic [NC-1:0]          ack_s2;
  logic [NC-1:0]          ack_s3;
  logic                   ack_low;
  logic                   ack_high;
  logic                   in_cycle;
  logic                   is_data;
  logic                   fifo_valid;
  logic [15:0]            fifo_data;
  logic                   pop;
  logic                   dma_mode;
  logic                   last_word;
  logic                   done;
  logic                   rd_frames;
  logic                   rd_bytes;
  logic [rx_dma_pkg::TIMER_W-1:0] timer;
  logic                   gap;

  // Auto switch alone leaves frames on chip; all-frames wins when both set
  assign dma_mode    = i_all_frames_by_dma_enable;
  assign buf_size    = i_host_buffer_size_select ? rx_dma_pkg::SIZE_64K
                                                 : rx_dma_pkg::SIZE_16K;
  // Header plus data words plus a pad word when the data word count is odd, to keep 32-bit alignment
  assign data_words  = ({1'b0, hdr.length} + 17'h00001) >> 1;
  assign total_words = {1'b0, data_words} + 18'h00002 + {17'h00000, data_words[0]};
  assign frame_bytes = total_words << 1;
  assign is_data     = (idx >= 18'h00002) && (idx < {1'b0, data_words} + 18'h00002);
  assign ack_low     = !ack_s2[chan] && !ack_s3[chan];
  assign ack_high    = ack_s2[chan] && ack_s3[chan];
  assign pop         = (state == rx_dma_pkg::ST_XFER) && ack_low && !in_cycle && is_data;
  assign last_word   = (idx == total_words - 18'h00001);
  assign done        = (state == rx_dma_pkg::ST_DONE);
  assign rd_frames   = i_reg_rd && (i_reg_addr == rx_dma_pkg::FRAMES_OFS);
  assign rd_bytes    = i_reg_rd && (i_reg_addr == rx_dma_pkg::BYTES_OFS);

  rx_word_fifo #(
    .WIDTH (16),
    .DEPTH (rx_dma_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_rx_valid),
    .i_in_data   (i_rx_data),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (pop)
  );

  // ****************************************************************
  // Grant pin synchronisers
  // ****************************************************************
  // Three stages; a level counts once the last two agree
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_s1 <= '1;
      ack_s2 <= '1;
      ack_s3 <= '1;
    end
    else
    begin
      ack_s1 <= i_transfer_grant_pin_n;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // Start once a frame is pending in DMA mode; committed space is not checked
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state    <= rx_dma_pkg::ST_IDLE;
      hdr      <= '0;
      idx      <= '0;
      in_cycle <= 1'b0;
      o_data_out <= 16'h0000;
      o_data_oe  <= 1'b0;
    end
    else
    begin
      case (state)
        rx_dma_pkg::ST_IDLE:
        begin
          if (dma_mode && i_frame_pending)
          begin
            hdr   <= i_frame_hdr;
            idx   <= '0;
            state <= rx_dma_pkg::ST_XFER;
          end
        end
        rx_dma_pkg::ST_XFER:
        begin
          if (!in_cycle && ack_low)
          begin
            in_cycle  <= 1'b1;
            o_data_oe <= 1'b1;
            if (idx == 18'h00000)
              o_data_out <= hdr.status;
            else if (idx == 18'h00001)
              o_data_out <= hdr.length;
            else if (is_data)
              o_data_out <= fifo_data;
            else
              o_data_out <= 16'h0000;
          end
          else if (in_cycle && ack_high)
          begin
            in_cycle  <= 1'b0;
            o_data_oe <= 1'b0;
            idx       <= idx + 18'h00001;
            if (last_word)
              state <= rx_dma_pkg::ST_DONE;
          end
        end
        rx_dma_pkg::ST_DONE:
          state <= rx_dma_pkg::ST_IDLE;
        default:
          state <= rx_dma_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Request pin with optional duty cycle
  // ****************************************************************
  // Timer only runs during a transfer; each frame starts in the high phase
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      timer <= '0;
      gap   <= 1'b0;
    end
    else if (state != rx_dma_pkg::ST_XFER || !i_request_duty_cycle_enable)
    begin
      timer <= '0;
      gap   <= 1'b0;
    end
    else if (!gap && timer == rx_dma_pkg::TIMER_W'(REQ_ON_CYCLES - 1))
    begin
      timer <= '0;
      gap   <= 1'b1;
    end
    else if (gap && timer == rx_dma_pkg::TIMER_W'(REQ_OFF_CYCLES - 1))
    begin
      timer <= '0;
      gap   <= 1'b0;
    end
    else
      timer <= timer + 1'b1;
  end

  // Data words wait for the FIFO so the host never reads a stale word
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_transfer_request_pin <= '0;
    else
    begin
      o_transfer_request_pin <= '0;
      if (state == rx_dma_pkg::ST_XFER && !last_word_done() && !gap
          && (!is_data || fifo_valid || in_cycle))
        o_transfer_request_pin[chan] <= 1'b1;
    end
  end

  // Request drops once the final word cycle has started
  function automatic logic last_word_done();
    last_word_done = last_word && in_cycle;
  endfunction

  // ****************************************************************
  // Offsets, counts and commitment
  // ****************************************************************
  // Set wins over the clear of a read in the same cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sof       <= rx_dma_pkg::REG_RST;
      wr_ofs    <= rx_dma_pkg::REG_RST;
      frames    <= '0;
      bytes     <= rx_dma_pkg::REG_RST;
      pending   <= '0;
      committed <= '0;
    end
    else
    begin
      if (done)
      begin
        sof    <= wr_ofs;
        wr_ofs <= 16'((({2'b00, wr_ofs} + frame_bytes) & (buf_size - 18'h00001)));
      end
      if (rd_frames)
        frames <= done ? 12'h001 : 12'h000;
      else if (done)
        frames <= frames + 12'h001;
      if (rd_bytes)
        bytes <= done ? frame_bytes[15:0] : 16'h0000;
      else if (done)
        bytes <= bytes + frame_bytes[15:0];
      // A read commits the moved span and frees what the last read committed
      if (rd_frames)
      begin
        committed <= pending;
        pending   <= done ? frame_bytes : 18'h00000;
      end
      else if (done)
        pending <= pending + frame_bytes;
    end
  end

  // ****************************************************************
  // Channel select and register reads
  // ****************************************************************
  // Values above two are ignored so the pin pair stays legal
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      chan <= rx_dma_pkg::CHAN_RST;
    else if (i_reg_wr && i_reg_addr == rx_dma_pkg::CHAN_SEL_OFS
             && i_reg_wdata <= {14'h0, rx_dma_pkg::CHAN_MAX})
      chan <= i_reg_wdata[1:0];
  end

  // Read data appears the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= 16'h0000;
    else if (i_reg_rd)
    begin
      if (i_reg_addr == rx_dma_pkg::CHAN_SEL_OFS)
        o_reg_rdata <= {14'h0000, chan};
      else if (i_reg_addr == rx_dma_pkg::SOF_OFS)
        o_reg_rdata <= sof;
      else if (i_reg_addr == rx_dma_pkg::FRAMES_OFS)
        o_reg_rdata <= {4'h0, frames};
      else if (i_reg_addr == rx_dma_pkg::BYTES_OFS)
        o_reg_rdata <= bytes;
      else
        o_reg_rdata <= 16'h0000;
    end
  end

  // ****************************************************************
  // Flags, events and lost frames
  // ****************************************************************
  // Flag mirrors the next frame count; a frame count read clears it unless a frame completes
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_frames_delivered_flag <= 1'b0;
      o_frames_delivered_irq  <= 1'b0;
      o_frame_free            <= 1'b0;
      o_receive_event_word    <= 16'h0000;
      o_lost_frame_counter    <= '0;
    end
    else
    begin
      o_frames_delivered_flag <= done || (!rd_frames && frames != '0);
      o_frames_delivered_irq  <= done && i_frames_delivered_irq_enable;
      o_frame_free            <= done;
      o_receive_event_word    <= dma_mode ? 16'h0000 : i_receive_event_word;
      if (i_frame_missed)
        o_lost_frame_counter <= o_lost_frame_counter + 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: hdl/rx_dma_pkg.sv
// Shared constants and types for the receive slave DMA block
package rx_dma_pkg;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [15:0] CHAN_SEL_OFS = 16'h0024;
  localparam logic [15:0] SOF_OFS      = 16'h0026;
  localparam logic [15:0] FRAMES_OFS   = 16'h0028;
  localparam logic [15:0] BYTES_OFS    = 16'h002A;
  localparam logic [1:0]  CHAN_RST     = 2'h0;
  localparam logic [1:0]  CHAN_MAX     = 2'h2;
  localparam logic [15:0] REG_RST      = 16'h0000;
  localparam int          NUM_CHAN     = 3;
  localparam int          FRAMES_W     = 12;

  // ****************************************************************
  // Host buffer sizes, in bytes
  // ****************************************************************
  localparam logic [17:0] SIZE_16K     = 18'h04000;
  localparam logic [17:0] SIZE_64K     = 18'h10000;

  // ****************************************************************
  // Request duty cycle timing
  // ****************************************************************
  localparam int CLK_MHZ     = 20;
  localparam int REQ_ON_US   = 28000;
  localparam int REQ_OFF_US  = 1300;
  localparam int REQ_ON_CYC  = REQ_ON_US * CLK_MHZ;
  localparam int REQ_OFF_CYC = REQ_OFF_US * CLK_MHZ;
  localparam int TIMER_W     = 20;
  localparam int FIFO_DEPTH  = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_DONE = 3'b100
  } dma_state_t;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] length;
  } frame_hdr_t;

endpackage

// file: testbench/host_dma_model.sv
// Behavioural host DMA controller answering the request pins
`timescale 1ns/1ns
`default_nettype none
module host_dma_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Set-up from the bench
  input  wire logic [1:0]  i_chan,
  input  wire logic        i_slow,
  // Device pins
  input  wire logic [2:0]  i_req,
  input  wire logic [15:0] i_data,
  input  wire logic        i_oe,
  output logic [2:0]       o_grant_n
);
  // ****************************************************************
  // Grant cycles
  // ****************************************************************
  logic [15:0] got[$];
  int          n;
  logic        seen;

  initial o_grant_n = 3'h7;

  // Low until one word is taken, then a rest; slow mode lets the FIFO fill
  always
  begin
    @(posedge i_clk);
    if (!i_rst && i_req[i_chan])
    begin
      #1 o_grant_n[i_chan] = 1'b0;
      seen = 1'b0;
      n = 0;
      while ((n < 4 || !seen) && n < 40)
      begin
        @(posedge i_clk);
        n++;
        if (i_oe && !seen)
        begin
          got.push_back(i_data);
          seen = 1'b1;
        end
      end
      #1 o_grant_n = 3'h7;
      repeat (i_slow ? 24 : 4) @(posedge i_clk);
    end
  end
endmodule
`default_nettype wire

// file: testbench/receive_slave_dma_tb_top.sv
// Self-checking bench for the receive slave DMA block
`timescale 1ns/1ns
`default_nettype none
module receive_slave_dma_tb_top;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic                   clk, rst, wr, rd, dma, auto, size, duty, irqe;
  logic                   pend, rxv, ready, free, miss, oe, flag, irq, slow;
  logic [15:0]            addr, wdata, rdata, rxd, evi, evo, dout;
  logic [2:0]             req, gnt;
  logic [1:0]             chan;
  logic [9:0]             lost;
  rx_dma_pkg::frame_hdr_t hdr;
  int                     n_fail, checks, irqs, stalls;

  receive_slave_dma #(.REQ_ON_CYCLES(40), .REQ_OFF_CYCLES(10)) u_dut (
    .i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_all_frames_by_dma_enable(dma),
    .i_auto_switch_dma_enable(auto), .i_host_buffer_size_select(size),
    .i_request_duty_cycle_enable(duty), .i_frames_delivered_irq_enable(irqe),
    .i_frame_pending(pend), .i_frame_hdr(hdr), .i_rx_valid(rxv), .i_rx_data(rxd),
    .o_rx_ready(ready), .o_frame_free(free), .i_frame_missed(miss),
    .i_receive_event_word(evi), .o_receive_event_word(evo), .o_transfer_request_pin(req),
    .i_transfer_grant_pin_n(gnt), .o_data_out(dout), .o_data_oe(oe),
    .o_frames_delivered_flag(flag), .o_frames_delivered_irq(irq), .o_lost_frame_counter(lost));

  host_dma_model u_host (.i_clk(clk), .i_rst(rst), .i_chan(chan), .i_slow(slow),
    .i_req(req), .i_data(dout), .i_oe(oe), .o_grant_n(gnt));

  // Free-running clock and interrupt pulse count
  always #25 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irqs++;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask

  // Read answers one cycle after the strobe is taken
  task automatic rchk(input string what, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    #1 rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'b0;
    chk(what, rdata, exp);
  endtask

  // One frame: push its words, wait for completion, compare host words
  task automatic frame(input logic [15:0] st, input logic [15:0] len);
    logic [15:0] exp[$];
    int          t;
    exp = {st, len};
    t = 0;
    u_host.got.delete();
    @(posedge clk);
    for (int i = 0; i < (len + 1) / 2; i++)
    begin
      #1 hdr = '{status: st, length: len};
      pend = 1'b1;
      rxv = 1'b1;
      rxd = 16'h0100 * len + 16'(i);
      exp.push_back(rxd);
      @(posedge clk);
      while (ready !== 1'b1 && t < 500)
      begin
        stalls++;
        t++;
        @(posedge clk);
      end
    end
    #1 rxv = 1'b0;
    pend = 1'b0;
    if (((len + 1) / 2) % 2) exp.push_back(16'h0000);
    t = 0;
    while (free !== 1'b1 && t < 3000)
    begin
      @(posedge clk);
      t++;
    end
    chk("frame free", free, 16'h0001);
    chk("flag set", flag, 16'h0001);
    chk("word count", 16'(u_host.got.size()), 16'(exp.size()));
    foreach (exp[i]) chk("host word", u_host.got[i], exp[i]);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    rchk("chan reset", rx_dma_pkg::CHAN_SEL_OFS, 16'h0000);
    rchk("frames reset", rx_dma_pkg::FRAMES_OFS, 16'h0000);
    rchk("bytes reset", rx_dma_pkg::BYTES_OFS, 16'h0000);
    rchk("unmapped", 16'h0030, 16'h0000);
    reg_wr(rx_dma_pkg::CHAN_SEL_OFS, 16'h0001);
    reg_wr(rx_dma_pkg::CHAN_SEL_OFS, 16'h0004);
    rchk("chan kept", rx_dma_pkg::CHAN_SEL_OFS, 16'h0001);
    reg_wr(rx_dma_pkg::SOF_OFS, 16'h1234);
    rchk("sof read only", rx_dma_pkg::SOF_OFS, 16'h0000);
    $display("test registers done");
  endtask

  task automatic t_modes;
    @(posedge clk);
    #1 auto = 1'b1;
    evi = 16'hBEEF;
    pend = 1'b1;
    miss = 1'b1;
    @(posedge clk);
    #1 miss = 1'b0;
    repeat (8) @(posedge clk);
    chk("no request", {13'h0, req}, 16'h0000);
    chk("event passed", evo, 16'hBEEF);
    #1 pend = 1'b0;
    dma = 1'b1;
    miss = 1'b1;
    repeat (2) @(posedge clk);
    #1 miss = 1'b0;
    @(posedge clk);
    chk("event hidden", evo, 16'h0000);
    chk("lost count", {6'h0, lost}, 16'h0003);
    #1 auto = 1'b0;
    $display("test modes done");
  endtask

  task automatic t_frames;
    irqe = 1'b1;
    chan = 2'h1;
    frame(16'hA5A5, 16'h0005);
    reg_wr(rx_dma_pkg::CHAN_SEL_OFS, 16'h0002);
    chan = 2'h2;
    irqe = 1'b0;
    duty = 1'b1;
    auto = 1'b1;
    slow = 1'b1;
    frame(16'h5A5A, 16'h000C);
    #1 duty = 1'b0;
    slow = 1'b0;
    chk("fifo refused", 16'(stalls > 0), 16'h0001);
    chk("irq count", 16'(irqs), 16'h0001);
    rchk("sof", rx_dma_pkg::SOF_OFS, 16'h000C);
    rchk("bytes", rx_dma_pkg::BYTES_OFS, 16'h001C);
    rchk("frames", rx_dma_pkg::FRAMES_OFS, 16'h0002);
    chk("flag clear", flag, 16'h0000);
    rchk("frames again", rx_dma_pkg::FRAMES_OFS, 16'h0000);
    rchk("bytes again", rx_dma_pkg::BYTES_OFS, 16'h0000);
    $display("test frames done");
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {clk, wr, rd, dma, auto, size, duty, irqe, pend, rxv, miss, slow} = '0;
    {addr, wdata, rxd, evi, chan, hdr, n_fail, checks, irqs, stalls} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    t_regs();
    t_modes();
    t_frames();
    print_verdict();
  end

  // Watchdog well past the expected run of a few hundred cycles
  initial
  begin
    #1000000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire

// file: testbench/rx_dma_checker.sv
// Concurrent checks on the ports of the receive slave DMA block
`timescale 1ns/1ns
`default_nettype none
module rx_dma_checker #(
  parameter int REQ_ON_CYCLES = 40,
  parameter int LOST_W        = 10
) (
  // Clock and reset
  input wire logic              i_clk,
  input wire logic              i_rst,
  // Register port and configuration
  input wire logic              i_reg_rd,
  input wire logic [15:0]       i_reg_addr,
  input wire logic [15:0]       o_reg_rdata,
  input wire logic              i_all_frames_by_dma_enable,
  input wire logic              i_request_duty_cycle_enable,
  input wire logic              i_frames_delivered_irq_enable,
  // Receive side and host pins
  input wire logic              i_frame_missed,
  input wire logic [15:0]       o_receive_event_word,
  input wire logic [2:0]        o_transfer_request_pin,
  input wire logic [2:0]        i_transfer_grant_pin_n,
  input wire logic              o_data_oe,
  // Status
  input wire logic              o_frame_free,
  input wire logic              o_frames_delivered_flag,
  input wire logic              o_frames_delivered_irq,
  input wire logic [LOST_W-1:0] o_lost_frame_counter
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [15:0] run;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Length of the current high phase of the request pin
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      run <= 16'h0000;
    else if (|o_transfer_request_pin)
      run <= run + 16'h0001;
    else
      run <= 16'h0000;

  a_req_one_chan: assert property ($onehot0(o_transfer_request_pin))
    else $error("more than one request pin high");
  a_word_granted: assert property ($rose(o_data_oe) |-> $past(i_transfer_grant_pin_n) != 3'h7)
    else $error("word driven without a grant");
  a_unmapped_zero: assert property (i_reg_rd && !(i_reg_addr inside {16'h0024, 16'h0026,
    16'h0028, 16'h002A}) |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_count_reserved: assert property (i_reg_rd && i_reg_addr == 16'h0028
    |=> o_reg_rdata[15:12] == 4'h0)
    else $error("frame count upper bits set");
  a_event_hidden: assert property (i_all_frames_by_dma_enable |=> o_receive_event_word == 16'h0000)
    else $error("event word visible in dma mode");
  a_irq_enabled: assert property (o_frames_delivered_irq |-> $past(i_frames_delivered_irq_enable)
    && o_frame_free)
    else $error("interrupt without enable or completion");
  a_free_flag: assert property (o_frame_free |-> o_frames_delivered_flag ##1 !o_frame_free)
    else $error("completion without flag or long pulse");
  a_lost_count: assert property (i_frame_missed |=> o_lost_frame_counter
    == LOST_W'($past(o_lost_frame_counter) + 1'b1))
    else $error("lost frame not counted");
  a_req_steady: assert property ($fell(|o_transfer_request_pin) && !i_request_duty_cycle_enable
    |-> ##[0:4] o_data_oe)
    else $error("request dropped before last word");
  a_duty_high: assert property (i_request_duty_cycle_enable |-> run <= REQ_ON_CYCLES + 2)
    else $error("request high phase too long");
endmodule
bind receive_slave_dma rx_dma_checker #(.REQ_ON_CYCLES(REQ_ON_CYCLES), .LOST_W(LOST_W)) u_chk (.*);
`default_nettype wire
